// >>> src/bridge_memory_window_decode.sv
// Overview of operation
// [R1] An access in the non-prefetchable window goes to the secondary bus.
// [R2] An access in the prefetchable window goes to the secondary bus.
// [R3] Register bits 15:4 are read/write and hold address bits 31:20.
// [R4] Bits 3:0 of each window register read zero and ignore writes.
// [R5] A base compares with address bits 19:0 as zero, on a 1-MB boundary.
// [R6] A limit compares with address bits 19:0 as ones, ending a 1-MB block.
// [R7] Both base registers read FFF0h after reset.
// [R8] Both limit registers read 0000h after reset.
// [R9] Software programs every base and limit before relying on a window.
// [R10] Software keeps windows apart from each other and from main memory.
// [R11] Control registers map non-prefetchable, local memory prefetchable.
// [R12] Forwarded accesses go to the graphics side, not the primary side.
// [R13] A window with base above limit matches nothing, as after reset.
`default_nettype none
module bridge_memory_window_decode
  import window_pkg::*;
#(
  parameter int CNT_WIDTH = CNT_W
)
(
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [PADDR_W-1:0]  paddr,
  input  wire logic [31:0]         pwdata,
  input  wire logic [3:0]          pstrb,
  output logic                     pready,
  output logic [31:0]              prdata,
  output logic                     pslverr,
  input  wire logic                req_valid,
  input  wire logic [ADDR_W-1:0]   req_addr,
  output logic                     fwd_valid,
  output logic [ADDR_W-1:0]        fwd_addr,
  output logic                     fwd_secondary,
  output logic                     fwd_prefetchable
);
  // ===========================================================================
  // Declarations.
  apb_state_e          state_q;
  logic                pready_q;
  logic [31:0]         prdata_q;
  logic                pslverr_q;
  logic [31:0]         rdata_d;
  logic                mapped_d;
  logic [IDX_W-1:0]    idx;
  logic                wr_commit;
  logic [FIELD_W-1:0]  window_q [NUM_REGS];
  logic [NUM_WIN-1:0]  hit;
  logic                fwd_valid_q;
  logic [ADDR_W-1:0]   fwd_addr_q;
  logic                fwd_secondary_q;
  logic                fwd_prefetchable_q;
  logic                last_np_q;
  logic                last_pf_q;
  logic [CNT_WIDTH-1:0] fwd_count_q;
  logic                first_q;

  window_cmp_if cmp_bus [NUM_WIN] ();

  assign idx       = paddr[PADDR_W-1:2];
  assign wr_commit = psel && penable && pready_q && pwrite;

  // ===========================================================================
  // APB slave: one wait cycle, then the answer from flip-flops.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= APB_IDLE;
    end
    else
    begin
      unique case (state_q)
        APB_IDLE:
        begin
          if (psel && penable)
          begin
            state_q <= APB_REPLY;
          end
        end
        APB_REPLY:
        begin
          state_q <= APB_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
    end
    else
    begin
      pready_q <= (state_q == APB_IDLE) && psel && penable;
    end
  end

  always_comb
  begin
    rdata_d  = DATA_ZERO;
    mapped_d = 1'b1;
    unique case (idx)
      IDX_NP_BASE:
      begin
        rdata_d[FIELD_MSB:FIELD_LSB] = window_q[0]; // [R4]
      end
      IDX_NP_LIMIT:
      begin
        rdata_d[FIELD_MSB:FIELD_LSB] = window_q[1];
      end
      IDX_PF_BASE:
      begin
        rdata_d[FIELD_MSB:FIELD_LSB] = window_q[2];
      end
      IDX_PF_LIMIT:
      begin
        rdata_d[FIELD_MSB:FIELD_LSB] = window_q[3];
      end
      IDX_STATUS:
      begin
        rdata_d[ST_NP_HIT] = last_np_q;
        rdata_d[ST_PF_HIT] = last_pf_q;
        rdata_d[ST_FWD]    = last_np_q || last_pf_q;
        rdata_d[ST_CNT_LSB +: CNT_WIDTH] = fwd_count_q;
      end
      default:
      begin
        mapped_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q  <= DATA_ZERO;
      pslverr_q <= 1'b0;
    end
    else if ((state_q == APB_IDLE) && psel && penable)
    begin
      prdata_q  <= pwrite ? DATA_ZERO : rdata_d;
      pslverr_q <= !mapped_d;
    end
    else
    begin
      prdata_q  <= DATA_ZERO;
      pslverr_q <= 1'b0;
    end
  end

  assign pready  = pready_q;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q;

  // ===========================================================================
  // Window registers: only the address field is stored; byte lanes honoured.
  for (genvar r = 0; r < NUM_REGS; r++)
  begin : g_reg
    localparam logic [15:0] RST = (r % 2 == 0) ? RST_BASE : RST_LIMIT;
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        window_q[r] <= RST[FIELD_MSB:FIELD_LSB]; // [R7] [R8]
      end
      else if (wr_commit && (idx == REG_IDX[r]))
      begin
        window_q[r] <= {pstrb[1] ? pwdata[15:8] : window_q[r][11:4],
                        pstrb[0] ? pwdata[7:4] : window_q[r][3:0]}; // [R3]
      end
    end
  end

  // ===========================================================================
  // Window comparators.
  for (genvar w = 0; w < NUM_WIN; w++)
  begin : g_win
    assign cmp_bus[w].base_field  = window_q[2*w];
    assign cmp_bus[w].limit_field = window_q[2*w+1];
    assign cmp_bus[w].addr        = req_addr;
    assign hit[w]                 = cmp_bus[w].hit;
    window_compare u_cmp (
      .bus (cmp_bus[w])
    );
  end

  // ===========================================================================
  // Routing decision, one cycle after the request.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fwd_valid_q        <= 1'b0;
      fwd_addr_q         <= DATA_ZERO;
      fwd_secondary_q    <= 1'b0;
      fwd_prefetchable_q <= 1'b0;
    end
    else
    begin
      fwd_valid_q        <= req_valid;
      fwd_addr_q         <= req_valid ? req_addr : fwd_addr_q;
      fwd_secondary_q    <= req_valid && (|hit); // [R1] [R2] [R12]
      fwd_prefetchable_q <= req_valid && hit[WIN_PF]; // [R2]
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      last_np_q   <= 1'b0;
      last_pf_q   <= 1'b0;
      fwd_count_q <= '0;
    end
    else if (req_valid)
    begin
      last_np_q <= hit[WIN_NP];
      last_pf_q <= hit[WIN_PF];
      if (hit[WIN_NP] || hit[WIN_PF])
      begin
        fwd_count_q <= fwd_count_q + 1'b1;
      end
    end
  end

  assign fwd_valid        = fwd_valid_q;
  assign fwd_addr         = fwd_addr_q;
  assign fwd_secondary    = fwd_secondary_q;
  assign fwd_prefetchable = fwd_prefetchable_q;

  // ===========================================================================
  // Checks.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      first_q <= 1'b1;
    end
    else
    begin
      first_q <= 1'b0;
    end
  end

  np_forward_a: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
    req_valid && ({window_q[0], BASE_FILL} <= req_addr)
    && (req_addr <= {window_q[1], LIMIT_FILL})
    |=> fwd_valid && fwd_secondary && (fwd_addr == $past(req_addr)))
    else $error("Non-prefetchable hit was not forwarded.");

  pf_forward_a: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
    req_valid && ({window_q[2], BASE_FILL} <= req_addr)
    && (req_addr <= {window_q[3], LIMIT_FILL})
    |=> fwd_secondary && fwd_prefetchable)
    else $error("Prefetchable hit was not forwarded.");

  field_write_a: assert property (@(posedge pclk) // [R3]
    disable iff (!presetn)
    wr_commit && (pstrb[1:0] == 2'b11) && (idx == IDX_PF_LIMIT)
    |=> window_q[3] == $past(pwdata[FIELD_MSB:FIELD_LSB]))
    else $error("Window field did not take the written value.");

  low_zero_a: assert property (@(posedge pclk) disable iff (!presetn) // [R4]
    (state_q == APB_IDLE) && psel && penable && !pwrite
    && (idx >= IDX_NP_BASE) && (idx <= IDX_PF_LIMIT)
    |=> pready && (prdata[3:0] == 4'h0) && (prdata[31:16] == 16'h0000))
    else $error("Window read returned nonzero low or upper bits.");

  base_align_a: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
    req_valid && (req_addr[31:20] == window_q[0])
    && (window_q[0] <= window_q[1])
    |=> fwd_secondary)
    else $error("Base block start was not matched.");

  limit_fill_a: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
    req_valid && (req_addr[31:20] == window_q[3])
    && (window_q[2] <= window_q[3])
    |=> fwd_secondary && fwd_prefetchable)
    else $error("Limit block end was not matched.");

  base_reset_a: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
    first_q |-> (window_q[0] == RST_BASE[FIELD_MSB:FIELD_LSB])
    && (window_q[2] == RST_BASE[FIELD_MSB:FIELD_LSB]))
    else $error("Base register reset value wrong.");

  limit_reset_a: assert property (@(posedge pclk) // [R8]
    disable iff (!presetn)
    first_q |-> (window_q[1] == RST_LIMIT[FIELD_MSB:FIELD_LSB])
    && (window_q[3] == RST_LIMIT[FIELD_MSB:FIELD_LSB]))
    else $error("Limit register reset value wrong.");

  secondary_only_a: assert property (@(posedge pclk) // [R12]
    disable iff (!presetn)
    fwd_secondary |-> fwd_valid && ($past(hit) != 2'b00))
    else $error("Secondary forward without a window hit.");

  empty_window_a: assert property (@(posedge pclk) // [R13]
    disable iff (!presetn)
    req_valid && (window_q[0] > window_q[1]) && (window_q[2] > window_q[3])
    |=> fwd_valid && !fwd_secondary)
    else $error("Inverted window forwarded an access.");
endmodule : bridge_memory_window_decode
`default_nettype wire

// >>> src/window_pkg.sv
`default_nettype none
package window_pkg;
  // ===========================================================================
  // Register map.
  // Register offsets are all word aligned, so each is kept as a word index.
  // The byte address on the bus is four times the index.
  localparam int          IDX_W        = 10;
  localparam int          PADDR_W      = 12;
  localparam logic [9:0]  IDX_NP_BASE  = 10'h020;
  localparam logic [9:0]  IDX_NP_LIMIT = 10'h022;
  localparam logic [9:0]  IDX_PF_BASE  = 10'h024;
  localparam logic [9:0]  IDX_PF_LIMIT = 10'h026;
  localparam logic [9:0]  IDX_STATUS   = 10'h028;

  // ===========================================================================
  // Window registers: slot order is base, limit, base, limit.
  localparam int          NUM_WIN      = 2;
  localparam int          NUM_REGS     = 4;
  localparam int          WIN_NP       = 0;
  localparam int          WIN_PF       = 1;
  localparam logic [9:0]  REG_IDX [NUM_REGS] = '{IDX_NP_BASE, IDX_NP_LIMIT,
                                                 IDX_PF_BASE, IDX_PF_LIMIT};

  // ===========================================================================
  // Field layout and reset values.
  localparam int           ADDR_W      = 32;
  localparam int           FIELD_W     = 12;
  localparam int           FIELD_LSB   = 4;
  localparam int           FIELD_MSB   = 15;
  localparam int           FILL_W      = 20;
  localparam logic [15:0]  RST_BASE    = 16'hFFF0;
  localparam logic [15:0]  RST_LIMIT   = 16'h0000;
  localparam logic [19:0]  BASE_FILL   = 20'h0_0000;
  localparam logic [19:0]  LIMIT_FILL  = 20'hF_FFFF;
  localparam logic [31:0]  DATA_ZERO   = 32'h0000_0000;

  // ===========================================================================
  // Status register layout.
  localparam int           ST_NP_HIT   = 0;
  localparam int           ST_PF_HIT   = 1;
  localparam int           ST_FWD      = 2;
  localparam int           ST_CNT_LSB  = 16;
  localparam int           CNT_W       = 16;

  typedef enum logic {
    APB_IDLE,
    APB_REPLY
  } apb_state_e;
endpackage : window_pkg
`default_nettype wire

// >>> src/window_cmp_if.sv
`default_nettype none
interface window_cmp_if;
  import window_pkg::*;
  logic [FIELD_W-1:0] base_field;
  logic [FIELD_W-1:0] limit_field;
  logic [ADDR_W-1:0]  addr;
  logic               hit;

  modport owner (output base_field, output limit_field, output addr,
                 input hit);
  modport cmp   (input base_field, input limit_field, input addr,
                 output hit);
endinterface : window_cmp_if
`default_nettype wire

// >>> src/window_compare.sv
`default_nettype none
module window_compare
  import window_pkg::*;
(
  window_cmp_if.cmp bus
);
  // ===========================================================================
  // Inclusive range check with the low address bits filled in.
  logic [ADDR_W-1:0] lo;
  logic [ADDR_W-1:0] hi;

  assign lo      = {bus.base_field, BASE_FILL}; // [R5]
  assign hi      = {bus.limit_field, LIMIT_FILL}; // [R6]
  // An inverted window can never satisfy both bounds.
  assign bus.hit = (lo <= bus.addr) && (bus.addr <= hi); // [R13]
endmodule : window_compare
`default_nettype wire

// >>> verification/gfx_target_model.sv
`default_nettype none
module gfx_target_model
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic fwd_valid,
  input  wire logic fwd_secondary,
  input  wire logic fwd_prefetchable,
  output var  int   ctrl_hits,
  output var  int   mem_hits
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Accepts only accesses routed to the secondary side and sorts them.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_hits <= 0;
      mem_hits  <= 0;
    end
    else if (fwd_valid === 1'b1 && fwd_secondary === 1'b1)
    begin
      if (fwd_prefetchable === 1'b1)
        mem_hits <= mem_hits + 1;
      else
        ctrl_hits <= ctrl_hits + 1;
    end
  end
endmodule : gfx_target_model
`default_nettype wire

// >>> verification/testbench.sv
`default_nettype none
module testbench;
  import window_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, req_valid;
  logic [11:0] paddr;
  logic [31:0] pwdata, req_addr, prdata, fwd_addr, rd;
  logic [3:0]  pstrb;
  logic        pready, pslverr, fwd_valid, fwd_secondary, fwd_prefetchable;
  logic        er;
  int          fail_count, checks_done, ctrl_hits, mem_hits;

  bridge_memory_window_decode dut_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .req_valid(req_valid), .req_addr(req_addr),
    .fwd_valid(fwd_valid), .fwd_addr(fwd_addr),
    .fwd_secondary(fwd_secondary), .fwd_prefetchable(fwd_prefetchable));
  gfx_target_model gfx_u (.pclk(pclk), .presetn(presetn),
    .fwd_valid(fwd_valid), .fwd_secondary(fwd_secondary),
    .fwd_prefetchable(fwd_prefetchable), .ctrl_hits(ctrl_hits),
    .mem_hits(mem_hits));

  // ==========================================================================
  // Shared tasks.
  task automatic chk(input string       nm,
                     input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // The master waits for pready with no limit of its own; the watchdog
  // ends a transfer that never completes.
  task automatic apb(input logic        w,
                     input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic dec(input logic [31:0] a, input logic s, input logic p);
    @(posedge pclk);
    req_valid <= 1'b1;
    req_addr  <= a;
    @(posedge pclk);
    req_valid <= 1'b0;
    #1;
    chk("fwd_valid", 32'h0000_0001, {31'h0, fwd_valid});
    chk("fwd_addr", a, fwd_addr);
    chk("fwd_secondary", {31'h0, s}, {31'h0, fwd_secondary});
    chk("fwd_prefetchable", {31'h0, p}, {31'h0, fwd_prefetchable});
  endtask : dec

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  // ==========================================================================
  // Scenarios.
  task automatic reset_state();
    logic [31:0] exp_v;
    for (int i = 0; i < NUM_REGS; i++)
    begin
      exp_v = (i % 2 == 0) ? 32'h0000_FFF0 : 32'h0000_0000;
      apb(1'b0, {REG_IDX[i], 2'b00}, 32'h0000_0000);
      chk("reset value", exp_v, rd);
    end
    dec(32'hFFFF_FFFF, 1'b0, 1'b0);
    dec(32'h0000_0000, 1'b0, 1'b0);
    dec(32'hFFF0_0000, 1'b0, 1'b0);
  endtask : reset_state

  task automatic program_regs();
    logic [31:0] wv [NUM_REGS];
    wv = '{32'hFFFF_100F, 32'hA5A5_1FF5,
           32'h1234_400A, 32'h0000_4011};
    for (int i = 0; i < NUM_REGS; i++)
    begin
      apb(1'b1, {REG_IDX[i], 2'b00}, wv[i]);
      chk("write pslverr", 32'h0000_0000, {31'h0, er});
      apb(1'b0, {REG_IDX[i], 2'b00}, 32'h0000_0000);
      chk("readback", wv[i] & 32'h0000_FFF0, rd);
    end
    apb(1'b0, 12'hFFC, 32'h0000_0000);
    chk("unmapped pslverr", 32'h0000_0001, {31'h0, er});
  endtask : program_regs

  task automatic window_edges();
    dec(32'h0FFF_FFFF, 1'b0, 1'b0);
    dec(32'h1000_0000, 1'b1, 1'b0);
    dec(32'h1FFF_FFFF, 1'b1, 1'b0);
    dec(32'h2000_0000, 1'b0, 1'b0);
    dec(32'h3FFF_FFFF, 1'b0, 1'b0);
    dec(32'h4000_0000, 1'b1, 1'b1);
    dec(32'h401F_FFFF, 1'b1, 1'b1);
    dec(32'h4020_0000, 1'b0, 1'b0);
    @(posedge pclk);
    chk("secondary ctrl count", 32'd2, ctrl_hits);
    chk("secondary mem count", 32'd2, mem_hits);
  endtask : window_edges

  // Byte lane 0 reaches field bits 3:0 and lane 1 field bits 11:4; the
  // status word counts forwarded requests and records the last hit.
  task automatic lane_and_status();
    apb(1'b0, {IDX_STATUS, 2'b00}, 32'h0000_0000);
    chk("status after edges", 32'h0004_0000, rd);
    pstrb <= 4'b0001;
    apb(1'b1, {IDX_NP_LIMIT, 2'b00}, 32'hFFFF_FFA0);
    apb(1'b0, {IDX_NP_LIMIT, 2'b00}, 32'h0000_0000);
    chk("lane 0 write", 32'h0000_1FA0, rd);
    pstrb <= 4'b0010;
    apb(1'b1, {IDX_NP_LIMIT, 2'b00}, 32'hFFFF_2B55);
    pstrb <= 4'hF;
    apb(1'b0, {IDX_NP_LIMIT, 2'b00}, 32'h0000_0000);
    chk("lane 1 write", 32'h0000_2BA0, rd);
    dec(32'h2BB0_0000, 1'b0, 1'b0);
    dec(32'h2BAF_FFFF, 1'b1, 1'b0);
    apb(1'b0, {IDX_STATUS, 2'b00}, 32'h0000_0000);
    chk("status after hit", 32'h0005_0005, rd);
  endtask : lane_and_status

  // ==========================================================================
  // Clock, watchdog and main sequence.
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  initial
  begin
    repeat (5000) @(posedge pclk);
    fail_count++;
    tally_and_finish();
  end

  initial
  begin
    fail_count  = 0;
    checks_done = 0;
    presetn     = 1'b0;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 12'h000;
    pwdata      = 32'h0000_0000;
    pstrb       = 4'hF;
    req_valid   = 1'b0;
    req_addr    = 32'h0000_0000;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    reset_state();
    program_regs();
    window_edges();
    lane_and_status();
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
